// *** rtl/lcpmc_map.vh ***
/*
 Constants for the LED charge pump mode control: mode codes, timing figures
 and the cycle counts derived from them at the 20 MHz control clock.
 Assumes it is included by its bare name from files under rtl/.
*/
`ifndef LCPMC_MAP_VH
`define LCPMC_MAP_VH

`define LCPMC_CLK_HZ          20000000
`define LCPMC_MODE_1X         2'h0
`define LCPMC_MODE_1P5X       2'h1
`define LCPMC_MODE_2X         2'h2
`define LCPMC_MODE_OFF        2'h3

// Switch clock, nominal frequency in kHz; 20 MHz / 900 kHz rounds to 22
`define LCPMC_OSC_KHZ         900
`define LCPMC_OSC_CYC         ((`LCPMC_CLK_HZ / 1000 + `LCPMC_OSC_KHZ / 2) / `LCPMC_OSC_KHZ)
// Dead time in ns, least time: rounds up, at least one cycle
`define LCPMC_DEAD_NS         15
`define LCPMC_DEAD_CYC        ((`LCPMC_DEAD_NS * 20 + 999) / 1000)
// Soft-start ramp in us
`define LCPMC_SOFT_US         150
`define LCPMC_SOFT_CYC        (`LCPMC_SOFT_US * 20)
// LED current on time after enable in us
`define LCPMC_LEDON_US        100
`define LCPMC_LEDON_CYC       (`LCPMC_LEDON_US * 20)
// Mode switching delay in us (2.5 ms)
`define LCPMC_WARM_US         2500
`define LCPMC_WARM_CYC        (`LCPMC_WARM_US * 20)
// Soft-start level width
`define LCPMC_RAMP_W          8

`endif

// *** rtl/lcpmc_sync.v ***
/*
 Two flip-flop synchroniser for one asynchronous level.
 Assumes the input comes from a pin or an analog comparator.
*/
`timescale 1ns/1ps
`default_nettype none
module lcpmc_sync (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Level
  input  wire d,
  output reg  q
);
  reg meta_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** rtl/lcpmc_phase.v ***
/*
 Free-running two-phase nonoverlapping switch clock generator.
 Assumes one control clock; phases separated by dead time on both edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcpmc_map.vh"
module lcpmc_phase #(
  parameter PERIOD_CYC = `LCPMC_OSC_CYC,
  parameter DEAD_CYC   = `LCPMC_DEAD_CYC
) (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Phases
  output reg  ph1,
  output reg  ph2
);
  localparam HALF = PERIOD_CYC / 2;
  reg [7:0] cnt_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      ph1   <= 1'b0;
      ph2   <= 1'b0;
    end else begin
      if (cnt_r == PERIOD_CYC - 1)
        cnt_r <= 8'h00;
      else
        cnt_r <= cnt_r + 8'h01;
      // Each phase is shortened by the dead time so both are never high
      ph1 <= (cnt_r >= DEAD_CYC) && (cnt_r < HALF);
      ph2 <= (cnt_r >= HALF + DEAD_CYC) && (cnt_r < PERIOD_CYC);
    end
  end
endmodule
`default_nettype wire

// *** rtl/lcpmc_core.v ***
/*
 LED charge pump mode control: start-up checks, 1x/1.5x/2x mode stepping with
 warm-up delay and soft-start ramp, switch drive, fault shutdown.
 Assumes comparator inputs from the analog front end (asynchronous, so synced
 here) and that the switch outputs drive level shifters of the power stage.
*/
// Operation
// - After enable, start in pass-through mode, supply tied straight to output.
// - Stay in pass-through while no dropout is seen.
// - On dropout in pass-through, soft-start then enter 1.5x mode.
// - On further dropout in 1.5x mode, step up to 2x mode.
// - Pump switches run from two phases never active together.
// - 2x: capacitors charge on alternate phases, other stacked to output.
// - 1.5x: capacitors series-charged on phase one, parallel-stacked on phase two.
// - Charge and discharge repeat from a free-running 900 kHz oscillator.
// - About 15 ns dead time between the two phases; the code gives one 50 ns clock cycle.
// - Overcurrent shuts off the high-power sections.
// - Enable low: all off, output disconnected, 43k pull-down on.
// - Thermal shutdown above 165 C, resume only at 150 C.
// - Thermal shutdown may cycle any number of times without latching.
// - On enable, weak pull-up first; refuse enable if output stays under 1 V.
// - Output pulled below 1 V in operation disables the device.
// - Output current ramps linearly over 150 us at start and each mode change. Code ramps 255 steps of 11 cycles, about 140 us.
// - After dropout wait 2.5 ms before stepping up a mode.
// - Only enable low returns to pass-through; re-enable restarts at pass-through. Code also returns to pass-through after thermal shutdown.
// - LED current regulated from sense pin error adjusting pump strength.
// - Dropout declared when sense pin voltage falls to about 40 mV.
// - LED current starts about 100 us after enable rises.
`timescale 1ns/1ps
`default_nettype none
`include "lcpmc_map.vh"
module lcpmc_core #(
  parameter SOFT_CYC  = `LCPMC_SOFT_CYC,
  parameter LEDON_CYC = `LCPMC_LEDON_CYC,
  parameter WARM_CYC  = `LCPMC_WARM_CYC,
  parameter RAMP_W    = `LCPMC_RAMP_W
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst,
  // Enable pin from external controller
  input  wire              enable_in,
  // Analog comparators
  input  wire              pump_output_above_1v,
  input  wire              led_sense_pin_dropout,
  input  wire              led_sense_pin_high,
  input  wire              overcurrent,
  input  wire              temp_above_165c,
  input  wire              temp_below_150c,
  // Output path control
  output reg               pass_switch_on,
  output reg               weak_pullup_on,
  output reg               pulldown_43k_on,
  output reg               led_current_on,
  // Flying capacitor switches
  output reg               c1_charge,
  output reg               c2_charge,
  output reg               c1_stack,
  output reg               c2_stack,
  output reg               series_charge,
  output reg               parallel_stack,
  // Strength and status
  output reg [RAMP_W-1:0]  pump_strength,
  output reg [1:0]         pump_mode,
  output reg               thermal_shutdown,
  output reg               short_fault
);
  localparam ST_OFF   = 3'h0;
  localparam ST_PROBE = 3'h1;
  localparam ST_RUN   = 3'h2;
  localparam ST_WARM  = 3'h3;
  localparam ST_SOFT  = 3'h4;
  localparam ST_FAULT = 3'h5;

  localparam [RAMP_W-1:0] RAMP_MAX = {RAMP_W{1'b1}};
  localparam [RAMP_W-1:0] RAMP_MID = {1'b1, {(RAMP_W-1){1'b0}}};
  localparam [RAMP_W-1:0] RAMP_ONE = {{(RAMP_W-1){1'b0}}, 1'b1};
  // Ramp steps evenly spaced so the full ramp takes at most SOFT_CYC cycles (step count rounds down)
  localparam STEP_CYC = SOFT_CYC / ((1 << RAMP_W) - 1);

  wire en_s;
  wire cpo_ok_s;
  wire drop_s;
  wire hi_s;
  wire oc_s;
  wire hot_s;
  wire cool_s;
  wire ph1;
  wire ph2;

  // One synchroniser per pin or comparator; all of them are clocked by clk
  localparam N_SYNC = 7;
  wire [N_SYNC-1:0] async_in;
  wire [N_SYNC-1:0] sync_out;

  assign async_in = {temp_below_150c, temp_above_165c, overcurrent, led_sense_pin_high,
                     led_sense_pin_dropout, pump_output_above_1v, enable_in};

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi = gi + 1) begin : g_sync
      lcpmc_sync u_sync (
        .clk (clk),
        .rst (rst),
        .d   (async_in[gi]),
        .q   (sync_out[gi])
      );
    end
  endgenerate

  assign en_s     = sync_out[0];
  assign cpo_ok_s = sync_out[1];
  assign drop_s   = sync_out[2];
  assign hi_s     = sync_out[3];
  assign oc_s     = sync_out[4];
  assign hot_s    = sync_out[5];
  assign cool_s   = sync_out[6];

  // Oscillator runs free; switches are gated by mode, not by stopping it
  lcpmc_phase u_phase (
    .clk (clk),
    .rst (rst),
    .ph1 (ph1),
    .ph2 (ph2)
  );

  reg [2:0]        state_r;
  reg [2:0]        state_nxt;
  reg [1:0]        mode_r;
  reg [1:0]        mode_nxt;
  reg [15:0]       tmr_r;
  reg [15:0]       tmr_nxt;
  reg [11:0]       ledon_r;
  reg [7:0]        step_r;
  reg [RAMP_W-1:0] ramp_r;
  reg              hot_r;
  reg              run_seen_r;

  // Thermal hysteresis latch, independent of enable so it never sticks
  always @(posedge clk or posedge rst) begin
    if (rst)
      hot_r <= 1'b0;
    else if (hot_s)
      hot_r <= 1'b1;
    else if (cool_s)
      hot_r <= 1'b0;
  end

  wire active = (state_r == ST_RUN) || (state_r == ST_WARM) || (state_r == ST_SOFT);

  always @* begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    tmr_nxt   = tmr_r;
    case (state_r)
      ST_OFF: begin
        mode_nxt = `LCPMC_MODE_1X;
        tmr_nxt  = 16'h0000;
        if (en_s && !hot_r)
          state_nxt = ST_PROBE;
      end
      ST_PROBE: begin
        // Weak pull-up charges the output; a short never passes this check
        tmr_nxt = tmr_r + 16'h0001;
        if (cpo_ok_s) begin
          state_nxt = ST_SOFT;
          tmr_nxt   = 16'h0000;
        end else if (tmr_r == LEDON_CYC[15:0]) begin
          state_nxt = ST_FAULT;
        end
      end
      ST_SOFT: begin
        if (ramp_r == RAMP_MAX)
          state_nxt = ST_RUN;
      end
      ST_RUN: begin
        tmr_nxt = 16'h0000;
        if (drop_s && (mode_r != `LCPMC_MODE_2X))
          state_nxt = ST_WARM;
      end
      ST_WARM: begin
        tmr_nxt = tmr_r + 16'h0001;
        if (!drop_s) begin
          state_nxt = ST_RUN;
        end else if (tmr_r == WARM_CYC[15:0] - 16'h0001) begin
          state_nxt = ST_SOFT;
          mode_nxt  = (mode_r == `LCPMC_MODE_1X) ? `LCPMC_MODE_1P5X :
                      `LCPMC_MODE_2X;
        end
      end
      ST_FAULT: begin
        // Held until enable drops or hot_r sets; either goes to OFF, and a retry follows
        mode_nxt = `LCPMC_MODE_OFF;
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (active && !cpo_ok_s)
      state_nxt = ST_FAULT;
    if (active && oc_s)
      state_nxt = ST_FAULT;
    if (hot_r && (state_r != ST_OFF))
      state_nxt = ST_OFF;
    if (!en_s)
      state_nxt = ST_OFF;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_OFF;
      mode_r  <= `LCPMC_MODE_1X;
      tmr_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  // Soft-start ramp restarts on entry to SOFT and rises one step per STEP_CYC
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_r <= {RAMP_W{1'b0}};
      step_r <= 8'h00;
    end else if (state_nxt == ST_SOFT && state_r != ST_SOFT) begin
      ramp_r <= {RAMP_W{1'b0}};
      step_r <= 8'h00;
    end else if (state_r == ST_SOFT) begin
      if (step_r == STEP_CYC[7:0] - 8'h01) begin
        step_r <= 8'h00;
        if (ramp_r != RAMP_MAX)
          ramp_r <= ramp_r + RAMP_ONE;
      end else begin
        step_r <= step_r + 8'h01;
      end
    end
  end

  // LED current on time counted from enable rising
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ledon_r    <= 12'h000;
      run_seen_r <= 1'b0;
    end else if (!en_s) begin
      ledon_r    <= 12'h000;
      run_seen_r <= 1'b0;
    end else if (ledon_r != LEDON_CYC[11:0]) begin
      ledon_r <= ledon_r + 12'h001;
    end else begin
      run_seen_r <= 1'b1;
    end
  end

  // Regulation: ramp caps strength; sense error nudges it up or down
  reg [RAMP_W-1:0] reg_r;
  always @(posedge clk or posedge rst) begin
    if (rst)
      reg_r <= RAMP_MID;
    else if (!active)
      reg_r <= RAMP_MID;
    else if (drop_s && reg_r != RAMP_MAX)
      reg_r <= reg_r + RAMP_ONE;
    else if (hi_s && reg_r != {RAMP_W{1'b0}})
      reg_r <= reg_r - RAMP_ONE;
  end

  // Overcurrent cuts the power path in the cycle it is seen, one cycle ahead
  // of FAULT, so a soft-start entry under overcurrent never closes a switch
  wire drive_ok = active && !oc_s;
  wire boost    = drive_ok && (mode_r != `LCPMC_MODE_1X);
  wire m15      = boost && (mode_r == `LCPMC_MODE_1P5X);
  wire m2       = boost && (mode_r == `LCPMC_MODE_2X);

  // Next values of the registered outputs
  reg              pass_nxt;
  reg              pullup_nxt;
  reg              pulldown_nxt;
  reg              ledcur_nxt;
  reg              c1_charge_nxt;
  reg              c2_charge_nxt;
  reg              c1_stack_nxt;
  reg              c2_stack_nxt;
  reg              series_nxt;
  reg              parallel_nxt;
  reg [RAMP_W-1:0] strength_nxt;
  reg [1:0]        pump_mode_nxt;

  always @* begin
    pass_nxt      = drive_ok && (mode_r == `LCPMC_MODE_1X);
    pullup_nxt    = (state_r == ST_PROBE);
    pulldown_nxt  = !en_s || (state_r == ST_OFF);
    ledcur_nxt    = drive_ok && run_seen_r;
    c1_charge_nxt = m2 && ph1;
    c2_stack_nxt  = m2 && ph1;
    c2_charge_nxt = m2 && ph2;
    c1_stack_nxt  = m2 && ph2;
    series_nxt    = m15 && ph1;
    parallel_nxt  = m15 && ph2;
    // The ramp caps the regulator in SOFT, so after a mode change the drive restarts from zero and rises with the ramp
    if (!drive_ok)
      strength_nxt = {RAMP_W{1'b0}};
    else if ((state_r == ST_SOFT) && (ramp_r < reg_r))
      strength_nxt = ramp_r;
    else
      strength_nxt = reg_r;
    pump_mode_nxt = drive_ok ? mode_r : `LCPMC_MODE_OFF;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pass_switch_on   <= 1'b0;
      weak_pullup_on   <= 1'b0;
      pulldown_43k_on  <= 1'b1;
      led_current_on   <= 1'b0;
      c1_charge        <= 1'b0;
      c2_charge        <= 1'b0;
      c1_stack         <= 1'b0;
      c2_stack         <= 1'b0;
      series_charge    <= 1'b0;
      parallel_stack   <= 1'b0;
      pump_strength    <= {RAMP_W{1'b0}};
      pump_mode        <= `LCPMC_MODE_OFF;
      thermal_shutdown <= 1'b0;
      short_fault      <= 1'b0;
    end else begin
      pass_switch_on   <= pass_nxt;
      weak_pullup_on   <= pullup_nxt;
      pulldown_43k_on  <= pulldown_nxt;
      led_current_on   <= ledcur_nxt;
      c1_charge        <= c1_charge_nxt;
      c2_stack         <= c2_stack_nxt;
      c2_charge        <= c2_charge_nxt;
      c1_stack         <= c1_stack_nxt;
      series_charge    <= series_nxt;
      parallel_stack   <= parallel_nxt;
      pump_strength    <= strength_nxt;
      pump_mode        <= pump_mode_nxt;
      thermal_shutdown <= hot_r;
      short_fault      <= (state_r == ST_FAULT);
    end
  end
endmodule
`default_nettype wire

// *** tb/lcpmc_core_monitor.sv ***
/*
 Checker for the charge pump mode control ports.
 Assumes one clock domain and a bind onto lcpmc_core.
*/
`timescale 1ns/1ps
`default_nettype none
module lcpmc_core_monitor #(
  parameter SOFT_CYC  = 3000,
  parameter LEDON_CYC = 2000,
  parameter WARM_CYC  = 50000,
  parameter RAMP_W    = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Inputs
  input wire logic              enable_in,
  input wire logic              pump_output_above_1v,
  input wire logic              led_sense_pin_dropout,
  input wire logic              led_sense_pin_high,
  input wire logic              overcurrent,
  input wire logic              temp_above_165c,
  input wire logic              temp_below_150c,
  // Outputs
  input wire logic              pass_switch_on,
  input wire logic              weak_pullup_on,
  input wire logic              pulldown_43k_on,
  input wire logic              led_current_on,
  input wire logic              c1_charge,
  input wire logic              c2_charge,
  input wire logic              c1_stack,
  input wire logic              c2_stack,
  input wire logic              series_charge,
  input wire logic              parallel_stack,
  input wire logic [RAMP_W-1:0] pump_strength,
  input wire logic [1:0]        pump_mode,
  input wire logic              thermal_shutdown,
  input wire logic              short_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_phase_apart:
    assert property (!(c1_charge && c2_charge) && !(series_charge && parallel_stack))
    else $error("switch phases overlap");
  a_dead_gap:
    assert property ($rose(c1_charge) || $rose(c2_charge) |-> !$past(c1_charge) && !$past(c2_charge))
    else $error("no dead cycle between phases");
  a_double_pair:
    assert property (c1_charge |-> c2_stack && !c1_stack && pump_mode == 2'h2)
    else $error("doubling switch pairing wrong");
  a_half_pair:
    assert property (series_charge || parallel_stack |-> pump_mode == 2'h1 && !c1_charge)
    else $error("series or parallel switch outside 1.5x");
  a_pass_only_1x:
    assert property (pass_switch_on |-> pump_mode == 2'h0 && !weak_pullup_on)
    else $error("pass switch outside 1x");
  a_off_on_low:
    assert property (!enable_in [*6] |-> pulldown_43k_on && !pass_switch_on && !led_current_on)
    else $error("not shut down with enable low");
  a_no_step_down:
    assert property (pump_mode == 2'h2 |=> pump_mode == 2'h2 || pump_mode == 2'h3)
    else $error("left doubling mode without shutdown");
  a_half_up_only:
    assert property (pump_mode == 2'h1 |=> pump_mode != 2'h0)
    else $error("fell from 1.5x to 1x");
  a_hot_off:
    assert property (temp_above_165c [*6] |-> thermal_shutdown && !pass_switch_on)
    else $error("still running while hot");
  a_oc_off:
    assert property (overcurrent [*6] |-> !led_current_on && !pass_switch_on)
    else $error("still running in overcurrent");
  a_short_off:
    assert property (short_fault |-> !led_current_on && !pass_switch_on && pump_strength == 0)
    else $error("running while short fault");
  a_probe_quiet:
    assert property (weak_pullup_on |-> !led_current_on && pump_strength == 0)
    else $error("drive during output probe");
  a_phase_period:
    assert property ($rose(c1_charge) |-> ##22 ($rose(c1_charge) || pump_mode != 2'h2))
    else $error("switch period not 22 cycles");
endmodule
bind lcpmc_core lcpmc_core_monitor #(.SOFT_CYC(SOFT_CYC), .LEDON_CYC(LEDON_CYC),
  .WARM_CYC(WARM_CYC), .RAMP_W(RAMP_W)) i_lcpmc_core_monitor (.*);
`default_nettype wire

// *** tb/lcpmc_load.sv ***
/*
 Output capacitor and LED model at the pump output.
 Assumes the bench commands shorts and dropout.
*/
`timescale 1ns/1ps
`default_nettype none
module lcpmc_load (
  // Clock
  input wire logic  clk,
  // Design drive
  input wire logic  weak_pullup_on,
  input wire logic  pass_switch_on,
  input wire logic  pulldown_43k_on,
  // Bench commands
  input wire logic  short_cmd,
  input wire logic  drop_cmd,
  // Comparators
  output wire logic pump_output_above_1v,
  output wire logic led_sense_pin_dropout,
  output wire logic led_sense_pin_high
);
  logic [2:0] lvl_r = 3'h0;
  // Capacitor takes a few cycles to charge, so a refusal is visible
  always @(posedge clk) begin
    if (short_cmd || pulldown_43k_on) lvl_r <= 3'h0;
    else if ((weak_pullup_on || pass_switch_on) && lvl_r != 3'h7) lvl_r <= lvl_r + 3'h1;
  end
  assign pump_output_above_1v = lvl_r > 3'h3;
  assign led_sense_pin_dropout = drop_cmd;
  assign led_sense_pin_high = ~drop_cmd;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 Bench for the charge pump mode control with shortened counts.
 Assumes the load model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam SC = 300;
  localparam LC = 50;
  localparam WC = 100;
  logic       clk, rst, en, oc, hot, cool, shrt, drop;
  wire        ok1v, dsen, shi, pass, wpu, pd, ledon, c1c, c2c, c1s, c2s, ser, par, tsd, sf;
  wire [7:0]  str;
  wire [1:0]  mode;
  int         errors, checks;
  lcpmc_core #(.SOFT_CYC(SC), .LEDON_CYC(LC), .WARM_CYC(WC)) i_lcpmc_core (
    .clk(clk), .rst(rst), .enable_in(en), .pump_output_above_1v(ok1v),
    .led_sense_pin_dropout(dsen), .led_sense_pin_high(shi), .overcurrent(oc),
    .temp_above_165c(hot), .temp_below_150c(cool), .pass_switch_on(pass),
    .weak_pullup_on(wpu), .pulldown_43k_on(pd), .led_current_on(ledon),
    .c1_charge(c1c), .c2_charge(c2c), .c1_stack(c1s), .c2_stack(c2s),
    .series_charge(ser), .parallel_stack(par), .pump_strength(str),
    .pump_mode(mode), .thermal_shutdown(tsd), .short_fault(sf));
  lcpmc_load i_lcpmc_load (.clk(clk), .weak_pullup_on(wpu), .pass_switch_on(pass),
    .pulldown_43k_on(pd), .short_cmd(shrt), .drop_cmd(drop),
    .pump_output_above_1v(ok1v), .led_sense_pin_dropout(dsen), .led_sense_pin_high(shi));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wmode(input logic [1:0] m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      step(1);
      n++;
    end
    chk("pump_mode", {6'h0, mode}, {6'h0, m});
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_start;
    int n;
    n = 0;
    en = 1'b1;
    while (ledon !== 1'b1 && n < LC + SC + 60) begin
      step(1);
      n++;
    end
    chk("led_on_delay", {7'h0, n >= LC && n < LC + SC + 60}, 8'h1);
    wmode(2'h0, 50);
    chk("pass_switch_on", {7'h0, pass}, 8'h1);
    step(300);
    chk("pump_mode_hold", {6'h0, mode}, 8'h0);
    $display("test start done");
  endtask
  task t_step;
    drop = 1'b1;
    step(WC / 2);
    chk("warm_wait", {6'h0, mode}, 8'h0);
    wmode(2'h1, WC + SC + 60);
    wait_flag: begin
      repeat (30) if (ser !== 1'b1) step(1);
    end
    chk("series_charge", {7'h0, ser}, 8'h1);
    chk("parallel_off", {7'h0, par}, 8'h0);
    wmode(2'h2, WC + SC + 60);
    repeat (30) if (c1c !== 1'b1) step(1);
    chk("c1_charge", {7'h0, c1c}, 8'h1);
    chk("c2_stack", {7'h0, c2s}, 8'h1);
    chk("c2_charge_off", {7'h0, c2c}, 8'h0);
    chk("c1_stack_off", {7'h0, c1s}, 8'h0);
    step(3 * WC);
    chk("mode_top", {6'h0, mode}, 8'h2);
    $display("test step done");
  endtask
  task t_reen;
    en = 1'b0;
    step(8);
    chk("pulldown_43k_on", {7'h0, pd}, 8'h1);
    chk("led_off", {7'h0, ledon}, 8'h0);
    drop = 1'b0;
    en = 1'b1;
    wmode(2'h0, LC + SC + 100);
    $display("test reenable done");
  endtask
  task t_hot;
    repeat (2) begin
      hot = 1'b1;
      cool = 1'b0;
      step(8);
      chk("thermal_on", {7'h0, tsd}, 8'h1);
      hot = 1'b0;
      step(8);
      chk("thermal_hold", {7'h0, tsd}, 8'h1);
      cool = 1'b1;
      wmode(2'h0, LC + SC + 100);
    end
    $display("test thermal done");
  endtask
  task t_fault;
    oc = 1'b1;
    step(8);
    chk("oc_led_off", {7'h0, ledon}, 8'h0);
    oc = 1'b0;
    shrt = 1'b1;
    en = 1'b0;
    step(6);
    en = 1'b1;
    repeat (LC + 40) if (sf !== 1'b1) step(1);
    chk("short_fault", {7'h0, sf}, 8'h1);
    shrt = 1'b0;
    en = 1'b0;
    step(6);
    en = 1'b1;
    wmode(2'h0, LC + SC + 100);
    shrt = 1'b1;
    step(8);
    chk("short_run", {7'h0, pass}, 8'h0);
    $display("test fault done");
  endtask
  initial begin
    {en, oc, hot, shrt, drop} = 5'h00;
    cool = 1'b1;
    rst = 1'b1;
    errors = 0;
    checks = 0;
    step(2);
    chk("reset_pulldown", {7'h0, pd}, 8'h1);
    chk("reset_mode", {6'h0, mode}, 8'h3);
    chk("reset_strength", str, 8'h00);
    rst = 1'b0;
    t_start;
    t_step;
    t_reen;
    t_hot;
    t_fault;
    print_verdict;
  end
  initial begin
    #(50 * 40000);
    errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
